/* File: bench/eso_master.sv */
`timescale 1ns/1ps
`default_nettype none
module eso_master import eso_pkg::*; (
	// Clock and reset
	input  wire logic        clock,
	input  wire logic        rstn,
	// Request side
	output logic             od_rd_req,
	output logic      [15:0] od_index,
	output logic      [7:0]  od_subidx,
	// Answer side
	input  wire logic        od_rd_ack,
	input  wire logic [31:0] od_rd_data,
	input  wire logic        od_rd_err
);
	// Idle bus at time zero
	initial begin
		od_rd_req = 1'b0;
		od_index  = 16'h0000;
		od_subidx = 8'h00;
	end

	// One object upload; the address is inverted once taken so a stale copy never matches
	task automatic rd(input logic [15:0] idx, input logic [7:0] sub,
		output logic [31:0] data, output logic err);
		int n;
		@(posedge clock);
		#1 od_rd_req = 1'b1;
		od_index  = idx;
		od_subidx = sub;
		@(posedge clock);
		#1 od_rd_req = 1'b0;
		od_index  = ~idx;
		od_subidx = ~sub;
		// Answer taken at the edge where acknowledge is sampled high
		n = 0;
		do begin
			@(posedge clock);
			n++;
		end while (od_rd_ack !== 1'b1 && n < 4);
		data = (od_rd_ack === 1'b1) ? od_rd_data : 32'hxxxx_xxxx;
		err  = (od_rd_ack === 1'b1) ? od_rd_err : 1'bx;
	endtask
endmodule // eso_master
`default_nettype wire

/* File: bench/eso_status_tb_top.sv */
`timescale 1ns/1ps
`default_nettype none
module eso_status_tb_top import eso_pkg::*;;
	// Design inputs and outputs
	logic        clock;
	logic        rstn;
	logic [15:0] op_params;
	logic [31:0] cust_steps;
	logic [31:0] cust_total;
	logic [31:0] preset_value;
	logic [31:0] lim_min;
	logic [31:0] lim_max;
	logic        preset_trig;
	logic        restore_defaults;
	eso_nmt_e    nmt_state;
	logic [31:0] pos_raw;
	logic        pos_strobe;
	logic        od_rd_req;
	logic [15:0] od_index;
	logic [7:0]  od_subidx;
	logic        od_rd_ack;
	logic [31:0] od_rd_data;
	logic        od_rd_err;
	logic [31:0] tx_pos;
	logic        tx_pos_valid;
	// Model state and bookkeeping
	logic [31:0] seed;
	logic [31:0] m_meas;
	logic [31:0] m_origin;
	integer      error_cnt;
	integer      total_checks;
	integer      cyc;

	eso_status eso_status_i (.clock(clock), .rstn(rstn), .op_params(op_params),
		.cust_steps(cust_steps), .cust_total(cust_total), .preset_value(preset_value),
		.lim_min(lim_min), .lim_max(lim_max), .preset_trig(preset_trig),
		.restore_defaults(restore_defaults), .nmt_state(nmt_state), .pos_raw(pos_raw),
		.pos_strobe(pos_strobe), .od_rd_req(od_rd_req), .od_index(od_index),
		.od_subidx(od_subidx), .od_rd_ack(od_rd_ack), .od_rd_data(od_rd_data),
		.od_rd_err(od_rd_err), .tx_pos(tx_pos), .tx_pos_valid(tx_pos_valid));

	eso_master eso_master_i (.clock(clock), .rstn(rstn), .od_rd_req(od_rd_req),
		.od_index(od_index), .od_subidx(od_subidx), .od_rd_ack(od_rd_ack),
		.od_rd_data(od_rd_data), .od_rd_err(od_rd_err));

	// Clock and hang guard; the ceiling is far above the roughly 600 cycles needed
	always #50 clock = ~clock;
	always @(posedge clock) begin
		cyc = cyc + 1;
		if (cyc == 5000) begin
			error_cnt = error_cnt + 1;
			end_sim();
		end
	end

	// Fixed-seed xorshift source
	function automatic logic [31:0] rnd();
		seed = seed ^ (seed << 13);
		seed = seed ^ (seed >> 17);
		seed = seed ^ (seed << 5);
		return seed;
	endfunction

	// Measured position from the sample and the current setup
	function automatic logic [31:0] f_meas(input logic [31:0] raw);
		logic [31:0] p;
		logic [31:0] rng;
		p   = raw;
		rng = 32'h0200_0000;
		if (op_params[ESO_BIT_SCALE]) begin
			p   = {13'h0000, raw[31:13]} * cust_steps + (({19'h00000, raw[12:0]} * cust_steps) >> 13);
			rng = cust_total;
		end
		if (op_params[ESO_BIT_CODE_SEQ]) begin
			p = rng - 32'h0000_0001 - p;
		end
		return p;
	endfunction

	// Expected status word for a given sent position
	function automatic logic [15:0] f_stat(input logic [31:0] tx);
		logic [15:0] s;
		s = 16'h0000;
		s[ESO_BIT_CODE_SEQ] = op_params[ESO_BIT_CODE_SEQ];
		s[ESO_BIT_SCALE]    = op_params[ESO_BIT_SCALE];
		s[ESO_BIT_LIM_MIN]  = op_params[ESO_BIT_LIM_MIN] && (tx < lim_min);
		s[ESO_BIT_LIM_MAX]  = op_params[ESO_BIT_LIM_MAX] && (tx > lim_max);
		s[ESO_BIT_OPER]     = (nmt_state == ESO_NMT_OPER);
		return s;
	endfunction

	// Single comparison point
	task automatic chk(input logic [31:0] seen, input logic [31:0] exp);
		total_checks = total_checks + 1;
		if (seen !== exp) begin
			error_cnt = error_cnt + 1;
			$display("[ERR] t=%0t seen=%h exp=%h", $time, seen, exp);
		end
	endtask

	// Object read with value and error flag compared
	task automatic rdchk(input logic [15:0] idx, input logic [7:0] sub,
		input logic [31:0] ev, input logic ee);
		logic [31:0] d;
		logic        e;
		eso_master_i.rd(idx, sub, d, e);
		chk(d, ev);
		chk({31'h0, e}, {31'h0, ee});
	endtask

	// One sensor sample through to the sent position and the status word
	task automatic sample();
		logic [31:0] tx;
		int          n;
		@(posedge clock);
		#1 pos_raw = rnd() & 32'h01FF_FFFF;
		pos_strobe = 1'b1;
		m_meas     = f_meas(pos_raw);
		tx         = m_meas + preset_value - m_origin;
		@(posedge clock);
		#1 pos_strobe = 1'b0;
		pos_raw    = ~pos_raw;
		n = 0;
		while (tx_pos_valid !== 1'b1 && n < 4) begin
			@(posedge clock);
			#1 n++;
		end
		chk({31'h0, tx_pos_valid}, 32'h0000_0001);
		chk(tx_pos, tx);
		repeat (2) @(posedge clock);
		rdchk(ESO_IDX_STATUS, ESO_SUB_0, {16'h0000, f_stat(tx)}, 1'b0);
	endtask

	task automatic end_sim();
		$display("Checks %0d, mismatches %0d", total_checks, error_cnt);
		if (error_cnt == 0 && total_checks > 0) begin
			$display("Simulation passed");
		end else begin
			$display("Simulation failed");
		end
		$finish;
	endtask

	// Main sequence
	initial begin
		logic [31:0] r;
		clock = 1'b0; rstn = 1'b0; op_params = 16'h0000; cust_steps = 32'h0000_2000;
		cust_total = 32'h0200_0000; preset_value = 32'h0000_0000; lim_min = 32'h0000_0000;
		lim_max = 32'hFFFF_FFFF; preset_trig = 1'b0; restore_defaults = 1'b0;
		nmt_state = ESO_NMT_STOPPED; pos_raw = 32'h0000_0000; pos_strobe = 1'b0;
		seed = 32'd82696; m_meas = 32'h0000_0000; m_origin = 32'h0000_0000;
		error_cnt = 0; total_checks = 0; cyc = 0;
		repeat (3) @(posedge clock);
		#1 rstn = 1'b1;
		// Object map after reset, with unknown places refused
		rdchk(ESO_IDX_STATUS, ESO_SUB_0, 32'h0000_0000, 1'b0);
		rdchk(ESO_IDX_STEPS, ESO_SUB_0, 32'h0000_2000, 1'b0);
		rdchk(ESO_IDX_TURNS, ESO_SUB_0, 32'h0000_1000, 1'b0);
		rdchk(ESO_IDX_ALARMS, ESO_SUB_0, 32'h0000_0000, 1'b0);
		rdchk(ESO_IDX_WARNS, ESO_SUB_0, 32'h0000_0000, 1'b0);
		rdchk(ESO_IDX_VERSION, ESO_SUB_0, ESO_VERSION_VAL, 1'b0);
		rdchk(ESO_IDX_HOURS, ESO_SUB_0, 32'hFFFF_FFFF, 1'b0);
		rdchk(ESO_IDX_ORIGIN, ESO_SUB_0, 32'h0000_0000, 1'b0);
		rdchk(ESO_IDX_ZSHIFT, ESO_SUB_1, 32'h0000_0000, 1'b0);
		rdchk(ESO_IDX_ZSHIFT, ESO_SUB_0, 32'h0000_0000, 1'b1);
		rdchk(16'h6503, ESO_SUB_0, 32'h0000_0000, 1'b1);
		$display("Test reset_map done");
		// Random setups, samples, presets and restores
		for (int i = 0; i < 48; i++) begin
			r = rnd();
			@(posedge clock);
			#1 op_params = r[15:0] & 16'h3005;
			nmt_state    = (r[17:16] == 2'b11) ? ESO_NMT_OPER : eso_nmt_e'(r[17:16]);
			cust_steps   = 32'h0000_0001 << r[21:18];
			cust_total   = cust_steps << 12;
			preset_value = rnd() & 32'h01FF_FFFF;
			lim_min      = rnd() & 32'h01FF_FFFF;
			lim_max      = rnd() & 32'h01FF_FFFF;
			sample();
			if (r[24]) begin
				@(posedge clock);
				#1 preset_trig   = !r[25] || r[26];
				restore_defaults = r[25];
				@(posedge clock);
				#1 preset_trig   = 1'b0;
				restore_defaults = 1'b0;
				m_origin = r[25] ? 32'h0000_0000 : m_meas;
				rdchk(ESO_IDX_ORIGIN, ESO_SUB_0, m_origin, 1'b0);
				chk(tx_pos, m_meas + preset_value - m_origin);
			end
		end
		$display("Test random_objects done");
		end_sim();
	end
endmodule // eso_status_tb_top
`default_nettype wire

/* File: rtl/eso_cmp.sv */
`timescale 1ns/1ps
`default_nettype none
module eso_cmp import eso_pkg::*; (
	// Clock and reset
	input  wire logic        clock,
	input  wire logic        rstn,
	// Position to judge
	input  wire logic [31:0] pos,
	input  wire logic        pos_valid,
	// Thresholds and enables
	input  wire logic        en_min,
	input  wire logic        en_max,
	input  wire logic [31:0] lim_min,
	input  wire logic [31:0] lim_max,
	// Flags
	output logic             below_min,
	output logic             above_max
);
	typedef struct packed {
		logic lo;
		logic hi;
	} eso_cmp_s;

	eso_cmp_s st_r;
	eso_cmp_s st_nxt;

	// Judged on every update; a disabled check reads clear after the next clock edge
	always_comb begin
		st_nxt = st_r;
		if (pos_valid) begin
			st_nxt.lo = pos < lim_min;
			st_nxt.hi = pos > lim_max;
		end
		if (!en_min) begin
			st_nxt.lo = 1'b0;
		end
		if (!en_max) begin
			st_nxt.hi = 1'b0;
		end
	end

	always_ff @(posedge clock or negedge rstn) begin
		if (!rstn) begin
			st_r <= '0;
		end else begin
			st_r <= st_nxt;
		end
	end

	assign below_min = st_r.lo;
	assign above_max = st_r.hi;

endmodule // eso_cmp
`default_nettype wire

/* File: rtl/eso_pkg.sv */
package eso_pkg;

	// Object dictionary indices and sub-indices
	localparam logic [15:0] ESO_IDX_STATUS  = 16'h6500;
	localparam logic [15:0] ESO_IDX_STEPS   = 16'h6501;
	localparam logic [15:0] ESO_IDX_TURNS   = 16'h6502;
	localparam logic [15:0] ESO_IDX_ALARMS  = 16'h6504;
	localparam logic [15:0] ESO_IDX_WARNS   = 16'h6506;
	localparam logic [15:0] ESO_IDX_VERSION = 16'h6507;
	localparam logic [15:0] ESO_IDX_HOURS   = 16'h6508;
	localparam logic [15:0] ESO_IDX_ORIGIN  = 16'h6509;
	localparam logic [15:0] ESO_IDX_ZSHIFT  = 16'h650A;
	localparam logic [7:0]  ESO_SUB_0       = 8'h00;
	localparam logic [7:0]  ESO_SUB_1       = 8'h01;

	// Status word bit positions, same as the operating parameter bits except the operational bit
	localparam int ESO_BIT_CODE_SEQ = 0;
	localparam int ESO_BIT_SCALE    = 2;
	localparam int ESO_BIT_LIM_MIN  = 12;
	localparam int ESO_BIT_LIM_MAX  = 13;
	localparam int ESO_BIT_OPER     = 15;

	// Fixed and reset values
	localparam logic [15:0] ESO_ALARMS_VAL  = 16'h0000;
	localparam logic [15:0] ESO_WARNS_VAL   = 16'h0000;
	localparam logic [31:0] ESO_HOURS_VAL   = 32'hFFFF_FFFF;
	localparam logic [31:0] ESO_ORIGIN_RST  = 32'h0000_0000;
	localparam logic [31:0] ESO_ZSHIFT_VAL  = 32'h0000_0000;
	localparam logic [15:0] ESO_STATUS_RST  = 16'h0000;
	localparam logic [31:0] ESO_ZERO32      = 32'h0000_0000;
	localparam logic [31:0] ESO_ONE32       = 32'h0000_0001;
	// Arbitrary version code
	localparam logic [31:0] ESO_VERSION_VAL = 32'h0000_0001;

	// Native sensor geometry
	localparam int          ESO_STEP_BITS    = 13;
	localparam logic [31:0] ESO_NATIVE_STEPS = 32'h0000_2000;
	localparam logic [15:0] ESO_NATIVE_TURNS = 16'h1000;
	localparam logic [31:0] ESO_NATIVE_TOTAL = 32'h0200_0000;

	// Network operating state
	typedef enum logic [1:0] {
		ESO_NMT_STOPPED = 2'b00,
		ESO_NMT_PREOP   = 2'b01,
		ESO_NMT_OPER    = 2'b10
	} eso_nmt_e;

endpackage

/* File: rtl/eso_scale.sv */
`timescale 1ns/1ps
`default_nettype none
module eso_scale import eso_pkg::*; (
	// Clock and reset
	input  wire logic        clock,
	input  wire logic        rstn,
	// Raw sensor sample
	input  wire logic [31:0] pos_raw,
	input  wire logic        pos_strobe,
	// Setup
	input  wire logic        scale_en,
	input  wire logic        ccw,
	input  wire logic [31:0] cust_steps,
	input  wire logic [31:0] cust_total,
	// Measured position
	output logic      [31:0] meas_pos,
	output logic             meas_valid
);
	typedef struct packed {
		logic [31:0] pos;
		logic        vld;
	} eso_scale_s;

	eso_scale_s st_r;
	eso_scale_s st_nxt;

	function automatic logic [63:0] eso_mul(input logic [31:0] a, input logic [31:0] b);
		eso_mul = 64'(a) * 64'(b);
	endfunction

	// Native or scaled count, then direction fold
	always_comb begin
		logic [31:0] turn;
		logic [31:0] step;
		logic [63:0] whole;
		logic [63:0] frac;
		logic [31:0] p;
		logic [31:0] range;
		turn  = pos_raw >> ESO_STEP_BITS;
		step  = pos_raw & (ESO_NATIVE_STEPS - ESO_ONE32);
		whole = eso_mul(turn, cust_steps);
		frac  = eso_mul(step, cust_steps);
		p     = pos_raw;
		range = ESO_NATIVE_TOTAL;
		if (scale_en) begin
			p     = whole[31:0] + frac[ESO_STEP_BITS +: 32];
			range = cust_total;
		end
		// Counting down from the top keeps the code span unchanged
		if (ccw) begin
			p = range - ESO_ONE32 - p;
		end
		st_nxt     = st_r;
		st_nxt.vld = pos_strobe;
		if (pos_strobe) begin
			st_nxt.pos = p;
		end
	end

	always_ff @(posedge clock or negedge rstn) begin
		if (!rstn) begin
			st_r <= '0;
		end else begin
			st_r <= st_nxt;
		end
	end

	assign meas_pos   = st_r.pos;
	assign meas_valid = st_r.vld;

	native_pass_a: assert property (@(posedge clock) disable iff (!rstn)
		pos_strobe && !scale_en && !ccw |=> meas_pos == $past(pos_raw))
		else $error("native position not passed through");

endmodule // eso_scale
`default_nettype wire

/* File: rtl/eso_status.sv */
`timescale 1ns/1ps
`default_nettype none
module eso_status import eso_pkg::*; (
	// Clock and reset
	input  wire logic        clock,
	input  wire logic        rstn,
	// Operating parameters and custom values
	input  wire logic [15:0] op_params,
	input  wire logic [31:0] cust_steps,
	input  wire logic [31:0] cust_total,
	input  wire logic [31:0] preset_value,
	input  wire logic [31:0] lim_min,
	input  wire logic [31:0] lim_max,
	// Events from the object dictionary side
	input  wire logic        preset_trig,
	input  wire logic        restore_defaults,
	input  wire eso_nmt_e    nmt_state,
	// Sensor sample
	input  wire logic [31:0] pos_raw,
	input  wire logic        pos_strobe,
	// Object read port
	input  wire logic        od_rd_req,
	input  wire logic [15:0] od_index,
	input  wire logic [7:0]  od_subidx,
	output logic             od_rd_ack,
	output logic      [31:0] od_rd_data,
	output logic             od_rd_err,
	// Sent position
	output logic      [31:0] tx_pos,
	output logic             tx_pos_valid
);
	typedef struct packed {
		logic [15:0] status;
		logic [31:0] origin;
		logic [31:0] tx;
		logic        tx_vld;
		logic        ack;
		logic        err;
		logic [31:0] data;
	} eso_status_s;

	eso_status_s st_r;
	eso_status_s st_nxt;

	logic [31:0] meas_pos;
	logic        meas_valid;
	logic        below_min;
	logic        above_max;
	logic [31:0] tx_cur;

	// Direction and scaling applied to the raw sample
	eso_scale u_scale (
		.clock      (clock),
		.rstn       (rstn),
		.pos_raw    (pos_raw),
		.pos_strobe (pos_strobe),
		.scale_en   (op_params[ESO_BIT_SCALE]),
		.ccw        (op_params[ESO_BIT_CODE_SEQ]),
		.cust_steps (cust_steps),
		.cust_total (cust_total),
		.meas_pos   (meas_pos),
		.meas_valid (meas_valid)
	);

	// Position sent to the master
	assign tx_cur = meas_pos + preset_value - st_r.origin;

	// Thresholds judge the sent position, as the master sees it
	eso_cmp u_cmp (
		.clock     (clock),
		.rstn      (rstn),
		.pos       (tx_cur),
		.pos_valid (meas_valid),
		.en_min    (op_params[ESO_BIT_LIM_MIN]),
		.en_max    (op_params[ESO_BIT_LIM_MAX]),
		.lim_min   (lim_min),
		.lim_max   (lim_max),
		.below_min (below_min),
		.above_max (above_max)
	);

	// Object lookup: hit flag over the 32-bit value, narrow objects zero-extended
	function automatic logic [32:0] eso_lookup(
		input logic [15:0] idx,
		input logic [7:0]  sub,
		input logic [15:0] status,
		input logic [31:0] origin
	);
		logic [32:0] r;
		r = {1'b0, ESO_ZERO32};
		if (sub == ESO_SUB_0) begin
			case (idx)
				ESO_IDX_STATUS:  r = {1'b1, 16'h0000, status};
				ESO_IDX_STEPS:   r = {1'b1, ESO_NATIVE_STEPS};
				ESO_IDX_TURNS:   r = {1'b1, 16'h0000, ESO_NATIVE_TURNS};
				ESO_IDX_ALARMS:  r = {1'b1, 16'h0000, ESO_ALARMS_VAL};
				ESO_IDX_WARNS:   r = {1'b1, 16'h0000, ESO_WARNS_VAL};
				ESO_IDX_VERSION: r = {1'b1, ESO_VERSION_VAL};
				ESO_IDX_HOURS:   r = {1'b1, ESO_HOURS_VAL};
				ESO_IDX_ORIGIN:  r = {1'b1, origin};
				default:         r = {1'b0, ESO_ZERO32};
			endcase
		end else if (sub == ESO_SUB_1 && idx == ESO_IDX_ZSHIFT) begin
			r = {1'b1, ESO_ZSHIFT_VAL};
		end
		eso_lookup = r;
	endfunction

	// Next state of every register
	always_comb begin
		logic [32:0] hit;
		hit    = eso_lookup(od_index, od_subidx, st_r.status, st_r.origin);
		st_nxt = st_r;

		// Status word rebuilt every cycle; unused bits stay zero
		st_nxt.status                   = ESO_STATUS_RST;
		st_nxt.status[ESO_BIT_CODE_SEQ] = op_params[ESO_BIT_CODE_SEQ];
		st_nxt.status[ESO_BIT_SCALE]    = op_params[ESO_BIT_SCALE];
		st_nxt.status[ESO_BIT_LIM_MIN]  = below_min;
		st_nxt.status[ESO_BIT_LIM_MAX]  = above_max;
		st_nxt.status[ESO_BIT_OPER]     = (nmt_state == ESO_NMT_OPER);

		// Restore beats preset: defaults must leave a clean zero
		if (restore_defaults) begin
			st_nxt.origin = ESO_ORIGIN_RST;
		end else if (preset_trig) begin
			st_nxt.origin = meas_pos;
		end

		// Sent position follows the origin in use this cycle
		st_nxt.tx     = tx_cur;
		st_nxt.tx_vld = meas_valid;

		// One-cycle read answer; unknown objects answer with the error flag
		st_nxt.ack = od_rd_req;
		st_nxt.err = 1'b0;
		if (od_rd_req) begin
			st_nxt.err  = !hit[32];
			st_nxt.data = hit[31:0];
		end
	end

	always_ff @(posedge clock or negedge rstn) begin
		if (!rstn) begin
			st_r        <= '0;
			st_r.status <= ESO_STATUS_RST;
			st_r.origin <= ESO_ORIGIN_RST;
		end else begin
			st_r <= st_nxt;
		end
	end

	// Outputs straight from flops
	assign od_rd_ack    = st_r.ack;
	assign od_rd_data   = st_r.data;
	assign od_rd_err    = st_r.err;
	assign tx_pos       = st_r.tx;
	assign tx_pos_valid = st_r.tx_vld;

	default clocking cb @(posedge clock); endclocking
	default disable iff (!rstn);

	// Helper: the sent position of the previous cycle
	logic [31:0] tx_d1;
	always_ff @(posedge clock or negedge rstn) begin
		if (!rstn) begin
			tx_d1 <= ESO_ZERO32;
		end else begin
			tx_d1 <= tx_cur;
		end
	end

	sequence s_min_hit;
		meas_valid && op_params[ESO_BIT_LIM_MIN] && (tx_cur < lim_min)
		##1 op_params[ESO_BIT_LIM_MIN];
	endsequence

	sequence s_max_hit;
		meas_valid && op_params[ESO_BIT_LIM_MAX] && (tx_cur > lim_max)
		##1 op_params[ESO_BIT_LIM_MAX];
	endsequence

	sequence s_rd_const(logic [15:0] idx);
		od_rd_req && od_index == idx && od_subidx == ESO_SUB_0;
	endsequence

	code_seq_a: assert property (
		od_rd_req && od_index == ESO_IDX_STATUS && od_subidx == ESO_SUB_0
		|-> ##1 od_rd_ack ##0 od_rd_data[ESO_BIT_CODE_SEQ] == $past(op_params[ESO_BIT_CODE_SEQ], 2))
		else $error("status direction bit does not follow configuration");

	scale_bit_a: assert property (
		$stable(op_params[ESO_BIT_SCALE]) |=>
		st_r.status[ESO_BIT_SCALE] == $past(op_params[ESO_BIT_SCALE]))
		else $error("status scaling bit does not follow configuration");

	lim_min_set_a: assert property (
		s_min_hit |=> st_r.status[ESO_BIT_LIM_MIN])
		else $error("lower threshold flag not raised");

	lim_min_off_a: assert property (
		!op_params[ESO_BIT_LIM_MIN] [*2] |=> !st_r.status[ESO_BIT_LIM_MIN])
		else $error("lower threshold flag set while disabled");

	lim_max_set_a: assert property (
		s_max_hit |=> st_r.status[ESO_BIT_LIM_MAX])
		else $error("upper threshold flag not raised");

	lim_max_off_a: assert property (
		!op_params[ESO_BIT_LIM_MAX] [*2] |=> !st_r.status[ESO_BIT_LIM_MAX])
		else $error("upper threshold flag set while disabled");

	oper_bit_a: assert property (
		nmt_state != ESO_NMT_OPER |=> !st_r.status[ESO_BIT_OPER])
		else $error("operational bit set outside operational state");

	alarms_zero_a: assert property (
		s_rd_const(ESO_IDX_ALARMS) |=> od_rd_ack && !od_rd_err && od_rd_data == ESO_ZERO32)
		else $error("supported alarms not zero");

	warns_zero_a: assert property (
		s_rd_const(ESO_IDX_WARNS) |=> od_rd_ack && !od_rd_err && od_rd_data == ESO_ZERO32)
		else $error("supported warnings not zero");

	hours_ones_a: assert property (
		s_rd_const(ESO_IDX_HOURS) |=> od_rd_data == ESO_HOURS_VAL)
		else $error("operating hours not all ones");

	origin_cap_a: assert property (
		preset_trig && !restore_defaults |=> tx_cur == preset_value + meas_pos - $past(meas_pos))
		else $error("preset did not capture position");

	origin_clr_a: assert property (
		restore_defaults |=> st_r.origin == ESO_ORIGIN_RST
		##1 (st_r.origin == ESO_ORIGIN_RST || $past(preset_trig)))
		else $error("origin not cleared by restore");

	tx_calc_a: assert property (
		meas_valid |=> tx_pos_valid && tx_pos == tx_d1)
		else $error("sent position does not match calculation");

	rd_ack_a: assert property (
		!od_rd_req |=> !od_rd_ack && !od_rd_err)
		else $error("answer without request");

	sequence s_zshift_rd(logic [7:0] sub);
		od_rd_req && od_index == ESO_IDX_ZSHIFT && od_subidx == sub;
	endsequence

	dir_bit_a: assert property (
		1'b1 |=> st_r.status[ESO_BIT_CODE_SEQ] == $past(op_params[ESO_BIT_CODE_SEQ]))
		else $error("status direction bit lags configuration");

	oper_set_a: assert property (
		nmt_state == ESO_NMT_OPER |=> st_r.status[ESO_BIT_OPER])
		else $error("operational bit clear in operational state");

	turns_word_a: assert property (
		s_rd_const(ESO_IDX_TURNS) |=> od_rd_data == {16'h0000, ESO_NATIVE_TURNS})
		else $error("native turn count wrong");

	steps_word_a: assert property (
		s_rd_const(ESO_IDX_STEPS) |=> !od_rd_err && od_rd_data == ESO_NATIVE_STEPS)
		else $error("native steps per turn wrong");

	version_word_a: assert property (
		s_rd_const(ESO_IDX_VERSION) |=> !od_rd_err && od_rd_data == ESO_VERSION_VAL)
		else $error("version word wrong");

	zshift_word_a: assert property (
		s_zshift_rd(ESO_SUB_1) |=> od_rd_ack && !od_rd_err && od_rd_data == ESO_ZSHIFT_VAL)
		else $error("factory zero shift wrong");

	zshift_sub_a: assert property (
		s_zshift_rd(ESO_SUB_0) |=> od_rd_ack && od_rd_err && od_rd_data == ESO_ZERO32)
		else $error("missing sub-index not refused");

	origin_read_a: assert property (
		s_rd_const(ESO_IDX_ORIGIN) |=> od_rd_data == $past(st_r.origin))
		else $error("origin read does not match register");

	origin_hold_a: assert property (
		!preset_trig && !restore_defaults |=> $stable(st_r.origin))
		else $error("origin changed without preset or restore");

	rd_answer_a: assert property (
		od_rd_req |=> od_rd_ack)
		else $error("request not answered in one cycle");

	tx_latency_a: assert property (
		pos_strobe |=> ##1 tx_pos_valid)
		else $error("sent position not valid two cycles after sample");

endmodule // eso_status
`default_nettype wire
